//--- hw/lhp_params.svh
`ifndef LHP_PARAMS_SVH
`define LHP_PARAMS_SVH

// Clock rate and instruction execution time.
`define LHP_CLK_MHZ        40
`define LHP_INSTR_TIME_NS  40000
`define LHP_INSTR_CYC      ((`LHP_INSTR_TIME_NS * `LHP_CLK_MHZ + 999) / 1000)

// Widths.
`define LHP_BYTE_W         8
`define LHP_AC_W           7
`define LHP_RAM_AW         8
`define LHP_RAM_DEPTH      256
`define LHP_CNT_W          12

// Reset values.
`define LHP_BYTE_RST       8'h00
`define LHP_AC_RST         7'h00
`define LHP_CNT_RST        12'h000
`define LHP_WIDTH8_RST     1'b1
`define LHP_INC_RST        1'b1

// Instruction field positions.
`define LHP_I_DDADDR_BIT   7
`define LHP_I_CGADDR_BIT   6
`define LHP_I_FSET_BIT     5
`define LHP_I_DL_BIT       4
`define LHP_I_ENTRY_BIT    2
`define LHP_I_ID_BIT       1
`define LHP_CG_AC_MASK     7'h3f

// Status byte layout.
`define LHP_BUSY_BIT       7

`endif

//--- hw/lhp_pkg.sv
package lhp_pkg;

    typedef enum logic [6:0] {
        LHP_IDLE  = 7'h01,
        LHP_EXEC  = 7'h02,
        LHP_WRITE = 7'h04,
        LHP_STEP  = 7'h08,
        LHP_ADV   = 7'h10,
        LHP_FETCH = 7'h20,
        LHP_LOAD  = 7'h40
    } lhp_state_t;

endpackage : lhp_pkg

//--- hw/lhp_ram_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "lhp_params.svh"

interface lhp_ram_if;
    logic                     wr_en;
    logic                     rd_en;
    logic [`LHP_RAM_AW-1:0]   addr;
    logic [`LHP_BYTE_W-1:0]   wdata;
    logic [`LHP_BYTE_W-1:0]   rdata;

    modport ctrl (output wr_en, output rd_en, output addr, output wdata, input rdata);
    modport mem  (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : lhp_ram_if

`default_nettype wire

//--- hw/lhp_ram.sv
`timescale 1ns/100ps
`default_nettype none
`include "lhp_params.svh"

module lhp_ram (
    // Clock.
    input  wire logic clk_in,
    // Port.
    lhp_ram_if.mem    ram
);

    logic [`LHP_BYTE_W-1:0] mem_r [`LHP_RAM_DEPTH];
    logic [`LHP_BYTE_W-1:0] rdata_r;

    always_ff @(posedge clk_in)
    begin
        if (ram.wr_en)
        begin
            mem_r[ram.addr] <= ram.wdata;
        end
        if (ram.rd_en)
        begin
            rdata_r <= mem_r[ram.addr];
        end
    end

    assign ram.rdata = rdata_r;

endmodule : lhp_ram

`default_nettype wire

//--- hw/lhp_host_port.sv
// Overview of operation
// - Offers 4-bit and 8-bit parallel host links.
// - Bus width chosen by bus_width_bit instruction.
// - Host traffic passes two 8-bit holding registers.
// - Data goes to most recently addressed RAM.
// - Data read prefetches next RAM location.
// - Data write moves into addressed RAM automatically.
// - Instruction register is write-only to host.
// - Select low, write: instruction code stored.
// - Select low, read: busy flag, address counter.
// - Select high, write: data byte stored.
// - Select high, read: data holding returned.
// - Busy high during operation; instructions refused.
// - Address counter steps by one each data access.
`timescale 1ns/100ps
`default_nettype none
`include "lhp_params.svh"

module lhp_host_port (
    // Clock and reset.
    input  wire logic                    clk_in,
    input  wire logic                    reset_n_in,
    // Parallel host pins.
    input  wire logic                    chip_sel_n_in,
    input  wire logic                    register_select_in,
    input  wire logic                    read_write_in,
    input  wire logic                    enable_in,
    input  wire logic [`LHP_BYTE_W-1:0]  bus_in,
    output var  logic [`LHP_BYTE_W-1:0]  bus_out,
    output var  logic                    bus_oe_out,
    // Status.
    output var  logic                    busy_flag_out,
    output var  logic                    bus_width_bit_out
);

    //--------------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------------

    logic                   cs_n_s1_r, cs_n_s2_r, rs_s1_r, rs_s2_r, rw_s1_r, rw_s2_r;
    logic                   en_s1_r, en_s2_r, en_q_r;
    logic [`LHP_BYTE_W-1:0] bus_s1_r, bus_s2_r, bus_q_r;
    logic                   cs_n_s1_nxt, cs_n_s2_nxt, rs_s1_nxt, rs_s2_nxt;
    logic                   rw_s1_nxt, rw_s2_nxt, en_s1_nxt, en_s2_nxt, en_q_nxt;
    logic [`LHP_BYTE_W-1:0] bus_s1_nxt, bus_s2_nxt, bus_q_nxt;

    always_comb
    begin
        cs_n_s1_nxt = chip_sel_n_in;
        cs_n_s2_nxt = cs_n_s1_r;
        rs_s1_nxt   = register_select_in;
        rs_s2_nxt   = rs_s1_r;
        rw_s1_nxt   = read_write_in;
        rw_s2_nxt   = rw_s1_r;
        en_s1_nxt   = enable_in;
        en_s2_nxt   = en_s1_r;
        en_q_nxt    = en_s2_r;
        bus_s1_nxt  = bus_in;
        bus_s2_nxt  = bus_s1_r;
        bus_q_nxt   = bus_s2_r;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cs_n_s1_r <= 1'b1;
            cs_n_s2_r <= 1'b1;
            rs_s1_r   <= 1'b0;
            rs_s2_r   <= 1'b0;
            rw_s1_r   <= 1'b0;
            rw_s2_r   <= 1'b0;
            en_s1_r   <= 1'b0;
            en_s2_r   <= 1'b0;
            en_q_r    <= 1'b0;
            bus_s1_r  <= `LHP_BYTE_RST;
            bus_s2_r  <= `LHP_BYTE_RST;
            bus_q_r   <= `LHP_BYTE_RST;
        end
        else
        begin
            cs_n_s1_r <= cs_n_s1_nxt;
            cs_n_s2_r <= cs_n_s2_nxt;
            rs_s1_r   <= rs_s1_nxt;
            rs_s2_r   <= rs_s2_nxt;
            rw_s1_r   <= rw_s1_nxt;
            rw_s2_r   <= rw_s2_nxt;
            en_s1_r   <= en_s1_nxt;
            en_s2_r   <= en_s2_nxt;
            en_q_r    <= en_q_nxt;
            bus_s1_r  <= bus_s1_nxt;
            bus_s2_r  <= bus_s2_nxt;
            bus_q_r   <= bus_q_nxt;
        end
    end

    //--------------------------------------------------------------------
    // Strobe decode
    //--------------------------------------------------------------------

    // A cycle opens on the rising enable edge and closes on the falling one.
    logic en_rise, en_fall;
    assign en_rise = en_s2_r & ~en_q_r & ~cs_n_s2_r;
    assign en_fall = ~en_s2_r & en_q_r & ~cs_n_s2_r;

    //--------------------------------------------------------------------
    // Control state
    //--------------------------------------------------------------------

    function automatic logic [`LHP_AC_W-1:0] ac_step(input logic [`LHP_AC_W-1:0] ac,
                                                      input logic                 inc);
        ac_step = inc ? ac + `LHP_AC_W'(1) : ac - `LHP_AC_W'(1);
    endfunction : ac_step

    lhp_pkg::lhp_state_t     state_r, state_nxt;
    logic [`LHP_BYTE_W-1:0]  instruction_holding_r, instruction_holding_nxt;
    logic [`LHP_BYTE_W-1:0]  data_holding_r, data_holding_nxt;
    logic [`LHP_AC_W-1:0]    address_counter_r, address_counter_nxt;
    logic                    glyph_sel_r, glyph_sel_nxt;
    logic                    bus_width_bit_r, bus_width_bit_nxt;
    logic                    inc_r, inc_nxt;
    logic                    half_r, half_nxt;
    logic [3:0]              hi_nib_r, hi_nib_nxt;
    logic [`LHP_CNT_W-1:0]   busy_cnt_r, busy_cnt_nxt;
    logic [`LHP_BYTE_W-1:0]  bus_out_r, bus_out_nxt;
    logic                    busy_flag;
    logic                    byte_done;
    logic [`LHP_BYTE_W-1:0]  wr_byte;
    logic [`LHP_BYTE_W-1:0]  rd_byte;

    lhp_ram_if ram ();

    lhp_ram u_ram (
        .clk_in (clk_in),
        .ram    (ram.mem)
    );

    assign busy_flag = (state_r != lhp_pkg::LHP_IDLE) || (busy_cnt_r != `LHP_CNT_RST);
    // Four-bit transfers use the upper pins, high nibble first.
    assign byte_done = en_fall & (bus_width_bit_r | half_r);
    assign wr_byte   = bus_width_bit_r ? bus_q_r : {hi_nib_r, bus_q_r[7:4]};
    // Status read never exposes the instruction register.
    assign rd_byte   = rs_s2_r ? data_holding_r
                               : {busy_flag, address_counter_r};

    always_comb
    begin
        state_nxt               = state_r;
        instruction_holding_nxt = instruction_holding_r;
        data_holding_nxt        = data_holding_r;
        address_counter_nxt     = address_counter_r;
        glyph_sel_nxt           = glyph_sel_r;
        bus_width_bit_nxt       = bus_width_bit_r;
        inc_nxt                 = inc_r;
        half_nxt                = half_r;
        hi_nib_nxt              = hi_nib_r;
        busy_cnt_nxt            = (busy_cnt_r != `LHP_CNT_RST) ? busy_cnt_r - `LHP_CNT_W'(1)
                                                               : busy_cnt_r;
        bus_out_nxt             = bus_out_r;
        ram.wr_en               = 1'b0;
        ram.rd_en               = 1'b0;
        ram.addr                = {glyph_sel_r, address_counter_r};
        ram.wdata               = data_holding_r;

        if (en_rise && rw_s2_r)
        begin
            bus_out_nxt = bus_width_bit_r ? rd_byte
                        : (half_r ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0});
        end
        if (en_fall)
        begin
            half_nxt   = ~bus_width_bit_r & ~half_r;
            hi_nib_nxt = bus_q_r[7:4];
        end
        // Strobes are taken only while idle; the host polls busy first.
        if (byte_done && !busy_flag)
        begin
            case ({rs_s2_r, rw_s2_r})
                2'b00:
                begin
                    instruction_holding_nxt = wr_byte;
                    state_nxt               = lhp_pkg::LHP_EXEC;
                end
                2'b10:
                begin
                    data_holding_nxt = wr_byte;
                    state_nxt        = lhp_pkg::LHP_WRITE;
                end
                2'b11:
                begin
                    state_nxt = lhp_pkg::LHP_ADV;
                end
                default:
                begin
                    state_nxt = state_r;
                end
            endcase
        end

        case (state_r)
            lhp_pkg::LHP_IDLE:
            begin
                state_nxt = state_nxt;
            end
            lhp_pkg::LHP_EXEC:
            begin
                busy_cnt_nxt = `LHP_CNT_W'(`LHP_INSTR_CYC);
                state_nxt    = lhp_pkg::LHP_IDLE;
                if (instruction_holding_r[`LHP_I_DDADDR_BIT])
                begin
                    address_counter_nxt = instruction_holding_r[`LHP_AC_W-1:0];
                    glyph_sel_nxt       = 1'b0;
                    state_nxt           = lhp_pkg::LHP_FETCH;
                end
                else if (instruction_holding_r[`LHP_I_CGADDR_BIT])
                begin
                    address_counter_nxt = instruction_holding_r[`LHP_AC_W-1:0]
                                        & `LHP_CG_AC_MASK;
                    glyph_sel_nxt       = 1'b1;
                    state_nxt           = lhp_pkg::LHP_FETCH;
                end
                else if (instruction_holding_r[`LHP_I_FSET_BIT])
                begin
                    bus_width_bit_nxt = instruction_holding_r[`LHP_I_DL_BIT];
                    half_nxt          = 1'b0;
                end
                else if (instruction_holding_r[`LHP_I_ENTRY_BIT])
                begin
                    inc_nxt = instruction_holding_r[`LHP_I_ID_BIT];
                end
            end
            lhp_pkg::LHP_WRITE:
            begin
                ram.wr_en = 1'b1;
                state_nxt = lhp_pkg::LHP_STEP;
            end
            lhp_pkg::LHP_STEP:
            begin
                address_counter_nxt = ac_step(address_counter_r, inc_r);
                state_nxt           = lhp_pkg::LHP_IDLE;
            end
            lhp_pkg::LHP_ADV:
            begin
                address_counter_nxt = ac_step(address_counter_r, inc_r);
                state_nxt           = lhp_pkg::LHP_FETCH;
            end
            lhp_pkg::LHP_FETCH:
            begin
                ram.rd_en = 1'b1;
                state_nxt = lhp_pkg::LHP_LOAD;
            end
            lhp_pkg::LHP_LOAD:
            begin
                data_holding_nxt = ram.rdata;
                state_nxt        = lhp_pkg::LHP_IDLE;
            end
            default:
            begin
                state_nxt = lhp_pkg::LHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_r               <= lhp_pkg::LHP_IDLE;
            instruction_holding_r <= `LHP_BYTE_RST;
            data_holding_r        <= `LHP_BYTE_RST;
            address_counter_r     <= `LHP_AC_RST;
            glyph_sel_r           <= 1'b0;
            bus_width_bit_r       <= `LHP_WIDTH8_RST;
            inc_r                 <= `LHP_INC_RST;
            half_r                <= 1'b0;
            hi_nib_r              <= 4'h0;
            busy_cnt_r            <= `LHP_CNT_RST;
            bus_out_r             <= `LHP_BYTE_RST;
        end
        else
        begin
            state_r               <= state_nxt;
            instruction_holding_r <= instruction_holding_nxt;
            data_holding_r        <= data_holding_nxt;
            address_counter_r     <= address_counter_nxt;
            glyph_sel_r           <= glyph_sel_nxt;
            bus_width_bit_r       <= bus_width_bit_nxt;
            inc_r                 <= inc_nxt;
            half_r                <= half_nxt;
            hi_nib_r              <= hi_nib_nxt;
            busy_cnt_r            <= busy_cnt_nxt;
            bus_out_r             <= bus_out_nxt;
        end
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------

    assign bus_out           = bus_out_r;
    assign bus_oe_out        = en_s2_r & en_q_r & rw_s2_r & ~cs_n_s2_r;
    assign busy_flag_out     = busy_flag;
    assign bus_width_bit_out = bus_width_bit_r;

endmodule : lhp_host_port

`default_nettype wire

//--- verif/lhp_host_port_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "lhp_params.svh"
module lhp_host_port_assertions (
    // Watched ports.
    input wire logic                   clk_in,
    input wire logic                   reset_n_in,
    input wire logic                   chip_sel_n_in,
    input wire logic                   register_select_in,
    input wire logic                   read_write_in,
    input wire logic                   enable_in,
    input wire logic [`LHP_BYTE_W-1:0] bus_in,
    input wire logic [`LHP_BYTE_W-1:0] bus_out,
    input wire logic                   bus_oe_out,
    input wire logic                   busy_flag_out,
    input wire logic                   bus_width_bit_out
);
    logic [11:0] busy_len_r;
    logic [11:0] busy_len_nxt;
    always_comb busy_len_nxt = busy_flag_out ? busy_len_r + 12'h001 : 12'h000;
    always_ff @(posedge clk_in or negedge reset_n_in)
        if (!reset_n_in)
            busy_len_r <= 12'h000;
        else
            busy_len_r <= busy_len_nxt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // An 8-bit write strobe ending while the port is idle.
    sequence taken_s(logic rs);
        $fell(enable_in) && !chip_sel_n_in && !read_write_in && register_select_in == rs
            && !busy_flag_out && bus_width_bit_out;
    endsequence
    rst_vals_a: assert property ($rose(reset_n_in) |-> !bus_oe_out && !busy_flag_out
        && bus_width_bit_out) else $error("reset values wrong");
    data_busy_a: assert property (taken_s(1'b1) |-> ##[2:6] busy_flag_out
        ##[1:6] !busy_flag_out) else $error("data write busy window wrong");
    ins_busy_a: assert property (taken_s(1'b0) |-> ##[2:6] busy_flag_out [*8])
        else $error("instruction did not raise busy");
    busy_len_a: assert property (busy_len_r < 12'h6a4)
        else $error("busy held too long");
    oe_read_a: assert property ($rose(bus_oe_out) |-> $past(enable_in) && $past(enable_in, 2)
        && $past(read_write_in, 2) && !$past(chip_sel_n_in, 2)) else $error("bus driven without read");
    cs_gate_a: assert property (chip_sel_n_in [*4] |-> !bus_oe_out)
        else $error("bus driven while deselected");
    out_hold_a: assert property (bus_oe_out && $past(bus_oe_out) |-> $stable(bus_out))
        else $error("read data moved while driven");
    nib_zero_a: assert property (bus_oe_out && !bus_width_bit_out |-> bus_out[3:0] == 4'h0)
        else $error("low nibble not zero");
    width_hold_a: assert property ($past(busy_flag_out, 3) && busy_flag_out
        |-> $stable(bus_width_bit_out)) else $error("width changed while busy");
endmodule : lhp_host_port_assertions
bind lhp_host_port lhp_host_port_assertions i_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .chip_sel_n_in(chip_sel_n_in),
    .register_select_in(register_select_in), .read_write_in(read_write_in),
    .enable_in(enable_in), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_out(bus_oe_out),
    .busy_flag_out(busy_flag_out), .bus_width_bit_out(bus_width_bit_out));
`default_nettype wire

//--- verif/lhp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lhp_host_model (
    // Clock.
    input  wire logic       clk_in,
    // Host pins.
    output var  logic       chip_sel_n_out,
    output var  logic       register_select_out,
    output var  logic       read_write_out,
    output var  logic       enable_out,
    output var  logic [7:0] data_out,
    input  wire logic [7:0] data_in
);
    logic [7:0] drv_r;
    logic [7:0] junk_r;
    logic       own_r;
    initial
    begin
        chip_sel_n_out = 1'b1;
        register_select_out = 1'b0;
        read_write_out = 1'b0;
        enable_out = 1'b0;
        drv_r = 8'h00;
        junk_r = 8'h5a;
        own_r = 1'b0;
    end
    // A released bus shows a pattern that changes every cycle.
    always @(negedge clk_in) junk_r <= ~junk_r;
    assign data_out = own_r ? drv_r : junk_r;
    task strobe(input logic rs, input logic rw, input logic [7:0] d, input logic sel,
                output logic [7:0] q);
        @(negedge clk_in);
        chip_sel_n_out = !sel;
        register_select_out = rs;
        read_write_out = rw;
        drv_r = d;
        own_r = !rw;
        repeat (3) @(negedge clk_in);
        enable_out = 1'b1;
        repeat (6) @(negedge clk_in);
        q = data_in;
        enable_out = 1'b0;
        repeat (5) @(negedge clk_in);
        chip_sel_n_out = 1'b1;
        own_r = 1'b0;
    endtask : strobe
endmodule : lhp_host_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    logic       clk_in;
    logic       reset_n_in;
    logic       cs_n, rs, rw, en, oe, busy, width, wide, up;
    logic [7:0] host_d, bus_w, bus_q, d, e;
    logic [6:0] ac_seen, b, ae;
    logic [31:0] seed;
    logic [7:0] mem [256];
    int         n_errors = 0;
    int         check_count = 0;
    int         cycles = 0;
    assign bus_w = oe ? bus_q : host_d;
    lhp_host_port i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .chip_sel_n_in(cs_n),
        .register_select_in(rs), .read_write_in(rw), .enable_in(en), .bus_in(bus_w),
        .bus_out(bus_q), .bus_oe_out(oe), .busy_flag_out(busy), .bus_width_bit_out(width));
    lhp_host_model i_host (.clk_in(clk_in), .chip_sel_n_out(cs_n), .register_select_out(rs),
        .read_write_out(rw), .enable_out(en), .data_out(host_d), .data_in(bus_w));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [6:0] step(input logic [6:0] a, input logic inc);
        return inc ? a + 7'h01 : a - 7'h01;
    endfunction : step
    task automatic xfer(input logic r, input logic w, input logic [7:0] v, output logic [7:0] o);
        logic [7:0] h;
        if (wide)
            i_host.strobe(r, w, v, 1'b1, o);
        else
        begin
            i_host.strobe(r, w, {v[7:4], 4'ha}, 1'b1, h);
            i_host.strobe(r, w, {v[3:0], 4'h5}, 1'b1, o);
            o = {h[7:4], o[7:4]};
        end
    endtask : xfer
    task automatic ready();
        logic [7:0] s;
        int         k;
        k = 0;
        do
        begin
            xfer(1'b0, 1'b1, 8'h00, s);
            k++;
        end
        while (s[7] !== 1'b0 && k < 400);
        ac_seen = s[6:0];
        `CHK(s[7], 1'b0)
    endtask : ready
    task automatic op(input logic r, input logic [7:0] v);
        logic [7:0] o;
        xfer(r, 1'b0, v, o);
        if (!r && v[7:5] == 3'b001)
            wide = v[4];
        ready();
    endtask : op
    task automatic rd(output logic [7:0] o);
        xfer(1'b1, 1'b1, 8'h00, o);
        ready();
    endtask : rd
    task give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    initial
    begin
        reset_n_in = 1'b0;
        wide = 1'b1;
        seed = 32'hb4967dd7;
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        reset_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        `CHK(width, 1'b1)
        `CHK(busy, 1'b0)
        `CHK(oe, 1'b0)
        $display("test reset done");
        for (int m = 0; m < 2; m++)
        begin
            up = (m == 0);
            op(1'b0, {6'h01, up, 1'b0});
            seed = xs(seed);
            b = 7'h08 + seed[6:0] % 7'h70;
            op(1'b0, {1'b1, b});
            ae = b;
            for (int i = 0; i < 4; i++)
            begin
                seed = xs(seed);
                d = seed[15:8];
                op(1'b1, d);
                mem[{1'b0, ae}] = d;
                ae = step(ae, up);
                `CHK(ac_seen, ae)
            end
            op(1'b0, {1'b1, b});
            ae = b;
            for (int i = 0; i < 4; i++)
            begin
                rd(d);
                `CHK(d, mem[{1'b0, ae}])
                ae = step(ae, up);
                `CHK(ac_seen, ae)
            end
            $display("test entry %0d done", m);
        end
        op(1'b0, 8'h06);
        b = b & 7'h3f;
        op(1'b0, {1'b1, b});
        op(1'b1, 8'h3c);
        op(1'b0, {2'b01, b[5:0]});
        op(1'b1, 8'hc3);
        op(1'b0, {1'b1, b});
        rd(d);
        `CHK(d, 8'h3c)
        op(1'b0, {2'b01, b[5:0]});
        rd(d);
        `CHK(d, 8'hc3)
        $display("test glyph done");
        xfer(1'b0, 1'b0, 8'h91, d);
        xfer(1'b0, 1'b1, 8'h00, d);
        `CHK(d[7], 1'b1)
        xfer(1'b0, 1'b0, 8'ha2, d);
        xfer(1'b0, 1'b0, 8'h20, d);
        ready();
        `CHK(ac_seen, 7'h11)
        `CHK(width, 1'b1)
        i_host.strobe(1'b1, 1'b0, 8'h77, 1'b0, d);
        ready();
        `CHK(ac_seen, 7'h11)
        $display("test busy done");
        op(1'b0, 8'h20);
        `CHK(width, 1'b0)
        seed = xs(seed);
        d = seed[23:16];
        op(1'b0, 8'h85);
        op(1'b1, d);
        `CHK(ac_seen, 7'h06)
        op(1'b1, ~d);
        op(1'b0, 8'h85);
        rd(e);
        `CHK(e, d)
        rd(e);
        `CHK(e, ~d)
        `CHK(ac_seen, 7'h07)
        op(1'b0, 8'h30);
        `CHK(width, 1'b1)
        $display("test nibble done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
